// File: common/sysctl_pkg.sv
// Purpose: constants and types for the clock, reset and power mode control block
// Assumes: 20 MHz system clock, byte wide special function register port
// Notes: watchdog and pin reset timing count slow internal oscillator edges
// Contract
// RQ1 - watchdog counts slow internal oscillator in fast/slow
// RQ2 - watchdog enable field 0x off, 10 run-only, 11 always
// RQ3 - prescale field selects 360/180/90/45 ms overflow
// RQ4 - clear bit zeroes counter, self-clears next cycle
// RQ5 - every device reset zeroes the watchdog counter
// RQ6 - writing 56h to command register resets device
// RQ7 - pin reset enable bit gates the reset pin
// RQ8 - low-voltage select picks 2.9, 2.3, off, 1.8 volts
// RQ9 - detect flag from droop, off in stop/saving
// RQ10 - detect flag valid only with lowest reset threshold; code also passes it with the reset select set to off
// RQ11 - after reset run slow mode on internal oscillator
// RQ12 - prescaler divides 16/4/2/1, resets to 11
// RQ13 - slow clock type writable only in fast mode
// RQ14 - fast clock type writable only in slow mode
// RQ15 - fast clock stop halts oscillator, slow-mode writable only
// RQ16 - source select changes only while fast stop clear
// RQ17 - illegal clock writes rejected, never stop plus fast
// RQ18 - peripheral clock stop gates peripherals during idle
// RQ19 - idle stops processor, ends on reset or interrupt
// RQ20 - stop halts clocks but watchdog, pin wake exits
// RQ21 - stop refused while enabled wake pin is low
// RQ22 - any enabled interrupt wakes idle, pins wake stop
// RQ23 - only power-on reset reloads configuration words
// RQ24 - power-on holds reset 40 ms warm-up
// RQ25 - reset pin held low two slow oscillator cycles
// RQ26 - enabled watchdog overflow resets the whole chip
// RQ27 - source and prescaler switch without short clock pulses
package sysctl_pkg;

  // ***************************************************
  // register offsets
  // ***************************************************
  localparam logic [7:0] OFS_POWER_MODE = 8'h87;
  localparam logic [7:0] OFS_OPTION = 8'h94;
  localparam logic [7:0] OFS_INT_FLAG = 8'h95;
  localparam logic [7:0] OFS_SW_COMMAND = 8'h97;
  localparam logic [7:0] OFS_CLOCK_CTRL = 8'hD8;
  localparam logic [7:0] OFS_AUX_ONE = 8'hF8;
  localparam logic [15:0] OFS_CFG_LOW = 16'h1FFE;
  localparam logic [15:0] OFS_CFG_HIGH = 16'h1FFF;

  // ***************************************************
  // field positions and reset values
  // ***************************************************
  localparam int BIT_IDLE = 0;
  localparam int BIT_STOP = 1;
  localparam int BIT_THREE_VOLT = 6;
  localparam int BIT_WDT_PSC_LO = 4;
  localparam int BIT_LVD_FLAG = 7;
  localparam int BIT_SLOW_TYPE = 7;
  localparam int BIT_FAST_TYPE = 6;
  localparam int BIT_PERIPH_STOP = 4;
  localparam int BIT_FAST_STOP = 3;
  localparam int BIT_SRC_SEL = 2;
  localparam int BIT_WDT_CLEAR = 7;
  localparam int BIT_WDEN_LO = 6;
  localparam int BIT_PIN_RST_EN = 6;
  localparam int BIT_LVSEL_LO = 4;
  localparam int BIT_POWER_SAVE = 2;
  localparam logic [7:0] RST_OPTION = 8'h00;
  localparam logic [7:0] RST_CLOCK_CTRL = 8'h03;
  localparam logic [7:0] RST_AUX_ONE = 8'h00;
  localparam logic [7:0] RST_POWER_MODE = 8'h00;
  localparam logic [7:0] SW_RESET_KEY = 8'h56;
  localparam logic [1:0] LVSEL_2V9 = 2'h0;
  localparam logic [1:0] LVSEL_2V3 = 2'h1;
  localparam logic [1:0] LVSEL_OFF = 2'h2;
  localparam logic [1:0] LVSEL_1V8 = 2'h3;

  // ***************************************************
  // timing
  // ***************************************************
  localparam int CLK_KHZ = 20000;
  localparam int SLOW_RC_KHZ = 24;
  localparam int WARMUP_MS = 40;
  localparam int WARMUP_CYC = WARMUP_MS * CLK_KHZ;
  localparam int WDT_MS_00 = 360;
  localparam int WDT_MS_01 = 180;
  localparam int WDT_MS_10 = 90;
  localparam int WDT_MS_11 = 45;
  localparam logic [13:0] WDT_TICKS_00 = 14'(WDT_MS_00 * SLOW_RC_KHZ);
  localparam logic [13:0] WDT_TICKS_01 = 14'(WDT_MS_01 * SLOW_RC_KHZ);
  localparam logic [13:0] WDT_TICKS_10 = 14'(WDT_MS_10 * SLOW_RC_KHZ);
  localparam logic [13:0] WDT_TICKS_11 = 14'(WDT_MS_11 * SLOW_RC_KHZ);
  localparam logic [1:0] PIN_RST_TICKS = 2'h2;
  localparam logic [2:0] RST_HOLD_CYC = 3'h4;

  // ***************************************************
  // types
  // ***************************************************
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_IDLE = 3'b010,
    ST_STOP = 3'b100
  } pmode_t;

  typedef struct packed {
    logic [2:0] ext_int_n;
    logic lv_below_1v8;
    logic lv_below_2v3;
    logic lv_below_2v9;
    logic reset_pin_n;
    logic fast_xtal;
    logic fast_rc;
    logic slow_xtal;
    logic slow_rc;
  } async_pins_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic cpu_tick;
    logic periph_tick;
    logic fast_osc_en;
    logic fast_xtal_sel;
    logic slow_xtal_sel;
    logic fast_mode;
  } clk_ctl_t;

endpackage

// File: verilog/sysctl_core.sv
// Purpose: clock source, prescaler, power modes, watchdog and reset control
// Assumes: oscillators and comparators arrive as pins sampled on clk_sys
// Notes: system clock is delivered as tick enables, not as a gated clock
`timescale 1ns/1ns
module sysctl_core
  import sysctl_pkg::*;
#(
  parameter int WARMUP_CYCLES = WARMUP_CYC
) (
  // clock and power-on reset
  input wire logic clk_sys,
  input wire logic reset,
  // asynchronous pins
  input wire async_pins_t pins_async,
  // special function register port
  input wire sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata_r,
  // flash configuration words and interrupt status
  input wire logic [7:0] flash_cfg_low,
  input wire logic [7:0] flash_cfg_high,
  input wire logic [2:0] pin_wake_en,
  input wire logic port1_wake,
  input wire logic enabled_irq,
  // outputs
  output logic [7:0] cfg_low_r,
  output logic [7:0] cfg_high_r,
  output clk_ctl_t clk_ctl_r,
  output logic device_reset_r,
  output pmode_t mode_r
);

  // ***************************************************
  // pin synchronisers
  // ***************************************************
  localparam int NP = $bits(async_pins_t);
  logic [NP-1:0] s1_r, s2_r, s3_r, lvl_r, rise;
  async_pins_t pin_lvl;
  async_pins_t pin_rise;

  // a change counts once the second and third stages agree
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_sync
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          s1_r[gi] <= 1'b0;
          s2_r[gi] <= 1'b0;
          s3_r[gi] <= 1'b0;
          lvl_r[gi] <= 1'b0;
        end else begin
          s1_r[gi] <= pins_async[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          if (s2_r[gi] == s3_r[gi]) begin
            lvl_r[gi] <= s3_r[gi];
          end
        end
      end
      assign rise[gi] = s2_r[gi] & s3_r[gi] & ~lvl_r[gi];
    end
  endgenerate
  assign pin_lvl = lvl_r;
  assign pin_rise = rise;

  // ***************************************************
  // reset sequencing
  // ***************************************************
  logic [31:0] warm_cnt_r;
  logic por_busy_r;
  logic [2:0] hold_cnt_r;
  logic rst_int;
  logic rst_req;
  logic sw_rst_req, pin_rst_req, lv_rst_req, wdt_rst_req;
  logic [1:0] pin_low_cnt_r;

  assign rst_int = reset | por_busy_r | (hold_cnt_r != 3'h0);
  assign rst_req = sw_rst_req | pin_rst_req | lv_rst_req | wdt_rst_req;

  // warm-up and configuration load happen only after power-on
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      warm_cnt_r <= 32'h0;
      por_busy_r <= 1'b1;
      cfg_low_r <= 8'h00;
      cfg_high_r <= 8'h00;
    end else if (por_busy_r) begin
      warm_cnt_r <= warm_cnt_r + 32'h1;
      if (warm_cnt_r == 32'(WARMUP_CYCLES - 1)) begin // RQ24
        por_busy_r <= 1'b0;
        cfg_low_r <= flash_cfg_low; // RQ23
        cfg_high_r <= flash_cfg_high; // RQ23
      end
    end
  end

  // other sources stretch reset but never reload the configuration
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hold_cnt_r <= 3'h0;
    end else if (!por_busy_r && rst_req) begin
      hold_cnt_r <= RST_HOLD_CYC; // RQ26
    end else if (hold_cnt_r != 3'h0) begin
      hold_cnt_r <= hold_cnt_r - 3'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      device_reset_r <= 1'b1;
    end else begin
      device_reset_r <= rst_int | rst_req;
    end
  end

  // reset pin must stay low two slow oscillator edges
  always_ff @(posedge clk_sys) begin
    if (reset || pin_lvl.reset_pin_n) begin
      pin_low_cnt_r <= 2'h0;
    end else if (pin_rise.slow_rc && pin_low_cnt_r != PIN_RST_TICKS) begin
      pin_low_cnt_r <= pin_low_cnt_r + 2'h1; // RQ25
    end
  end
  assign pin_rst_req = cfg_high_r[BIT_PIN_RST_EN] &&
                       pin_low_cnt_r == PIN_RST_TICKS; // RQ7

  // low-voltage reset threshold per select field
  logic [1:0] lvsel;
  assign lvsel = cfg_high_r[BIT_LVSEL_LO +: 2];
  always_comb begin
    if (lvsel == LVSEL_2V9) begin // RQ8
      lv_rst_req = pin_lvl.lv_below_2v9;
    end else if (lvsel == LVSEL_2V3) begin
      lv_rst_req = pin_lvl.lv_below_2v3;
    end else if (lvsel == LVSEL_1V8) begin
      lv_rst_req = pin_lvl.lv_below_1v8;
    end else begin
      lv_rst_req = 1'b0;
    end
  end

  // ***************************************************
  // register writes
  // ***************************************************
  logic [7:0] pwr_r, option_r, clkreg_r, aux_r;
  logic wr_pwr, wr_clk, wr_aux, stop_block;
  assign wr_pwr = sfr_req.wr && sfr_req.addr == OFS_POWER_MODE;
  assign wr_clk = sfr_req.wr && sfr_req.addr == OFS_CLOCK_CTRL;
  assign wr_aux = sfr_req.wr && sfr_req.addr == OFS_AUX_ONE;
  assign sw_rst_req = sfr_req.wr && sfr_req.addr == OFS_SW_COMMAND &&
                      sfr_req.wdata == SW_RESET_KEY; // RQ6

  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      option_r <= RST_OPTION;
    end else if (sfr_req.wr && sfr_req.addr == OFS_OPTION) begin
      option_r <= sfr_req.wdata;
    end
  end

  // watchdog clear bit self-clears one cycle after being written
  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      aux_r <= RST_AUX_ONE;
    end else if (wr_aux) begin
      aux_r <= sfr_req.wdata & 8'hF9;
    end else begin
      aux_r[BIT_WDT_CLEAR] <= 1'b0; // RQ4
    end
  end

  // clock control: type, fast stop and source bits are guarded; illegal bits keep old value
  logic [7:0] clk_wd;
  logic fast_sel, fast_stop, both_bad;
  assign clk_wd = sfr_req.wdata;
  assign fast_sel = clkreg_r[BIT_SRC_SEL];
  assign fast_stop = clkreg_r[BIT_FAST_STOP];
  assign both_bad = clk_wd[BIT_FAST_STOP] & clk_wd[BIT_SRC_SEL]; // RQ17
  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      clkreg_r <= RST_CLOCK_CTRL; // RQ11 RQ12
    end else if (wr_clk) begin
      clkreg_r[1:0] <= clk_wd[1:0];
      clkreg_r[BIT_PERIPH_STOP] <= clk_wd[BIT_PERIPH_STOP];
      if (fast_sel) begin
        clkreg_r[BIT_SLOW_TYPE] <= clk_wd[BIT_SLOW_TYPE]; // RQ13
      end
      if (!fast_sel) begin
        clkreg_r[BIT_FAST_TYPE] <= clk_wd[BIT_FAST_TYPE]; // RQ14
      end
      if (!fast_sel && !both_bad) begin
        clkreg_r[BIT_FAST_STOP] <= clk_wd[BIT_FAST_STOP]; // RQ15 RQ17
      end
      if (!fast_stop && !both_bad) begin
        clkreg_r[BIT_SRC_SEL] <= clk_wd[BIT_SRC_SEL]; // RQ16 RQ17
      end
    end
  end

  // ***************************************************
  // power mode state machine
  // ***************************************************
  logic stop_wake, idle_wake;
  assign stop_block = |(~pin_lvl.ext_int_n & pin_wake_en); // RQ21
  assign stop_wake = stop_block | port1_wake; // RQ22
  assign idle_wake = enabled_irq; // RQ22

  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      mode_r <= ST_RUN;
      pwr_r <= RST_POWER_MODE;
    end else begin
      case (mode_r)
        ST_RUN: begin
          if (wr_pwr) begin
            pwr_r <= sfr_req.wdata & 8'h8F;
            if (sfr_req.wdata[BIT_STOP] && !stop_block) begin
              mode_r <= ST_STOP; // RQ20
            end else if (sfr_req.wdata[BIT_IDLE]) begin
              mode_r <= ST_IDLE; // RQ19
            end
            if (stop_block) begin
              pwr_r[BIT_STOP] <= 1'b0; // RQ21
            end
          end
        end
        ST_IDLE: begin
          if (idle_wake) begin
            mode_r <= ST_RUN; // RQ19
            pwr_r[BIT_IDLE] <= 1'b0;
          end
        end
        ST_STOP: begin
          if (stop_wake) begin
            mode_r <= ST_RUN; // RQ20
            pwr_r[BIT_STOP] <= 1'b0;
            pwr_r[BIT_IDLE] <= 1'b0;
          end
        end
        default: begin
          mode_r <= ST_RUN;
        end
      endcase
    end
  end

  // ***************************************************
  // watchdog
  // ***************************************************
  logic [13:0] wdt_cnt_r, wdt_limit;
  logic [1:0] wden;
  logic wdt_run, wdt_ovf;
  assign wden = cfg_low_r[BIT_WDEN_LO +: 2];
  // counting in idle/stop only when the always-on setting is chosen
  assign wdt_run = (mode_r == ST_RUN) || (wden == 2'h3); // RQ1 RQ20
  always_comb begin
    case (option_r[BIT_WDT_PSC_LO +: 2]) // RQ3
      2'h0: wdt_limit = WDT_TICKS_00;
      2'h1: wdt_limit = WDT_TICKS_01;
      2'h2: wdt_limit = WDT_TICKS_10;
      default: wdt_limit = WDT_TICKS_11;
    endcase
  end
  assign wdt_ovf = wdt_run && pin_rise.slow_rc && wdt_cnt_r >= wdt_limit - 14'h1;
  assign wdt_rst_req = wdt_ovf && wden[1] && (mode_r == ST_RUN || wden[0]); // RQ2 RQ26

  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      wdt_cnt_r <= 14'h0; // RQ5
    end else if (aux_r[BIT_WDT_CLEAR] || wdt_ovf) begin
      wdt_cnt_r <= 14'h0; // RQ4
    end else if (wdt_run && pin_rise.slow_rc) begin
      wdt_cnt_r <= wdt_cnt_r + 14'h1; // RQ1
    end
  end

  // ***************************************************
  // system clock divider
  // ***************************************************
  logic act_fast_r;
  logic [1:0] act_psc_r;
  logic [3:0] div_cnt_r, div_term;
  logic src_tick, sys_tick;
  // fast clock stays on only while not stopped and not in stop mode
  logic fast_on;
  assign fast_on = !fast_stop && mode_r != ST_STOP; // RQ15 RQ20
  always_comb begin
    if (act_fast_r) begin
      src_tick = clkreg_r[BIT_FAST_TYPE] ? pin_rise.fast_xtal : pin_rise.fast_rc;
    end else begin
      src_tick = clkreg_r[BIT_SLOW_TYPE] ? pin_rise.slow_xtal : pin_rise.slow_rc;
    end
    case (act_psc_r) // RQ12
      2'h0: div_term = 4'hF;
      2'h1: div_term = 4'h3;
      2'h2: div_term = 4'h1;
      default: div_term = 4'h0;
    endcase
  end
  assign sys_tick = src_tick && div_cnt_r == div_term;

  // new source and divisor are taken only at a period boundary, so
  // no period is cut short; costs up to one old period of latency
  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      act_fast_r <= 1'b0; // RQ11
      act_psc_r <= RST_CLOCK_CTRL[1:0];
      div_cnt_r <= 4'h0;
    end else if (sys_tick) begin
      act_fast_r <= fast_sel; // RQ27
      act_psc_r <= clkreg_r[1:0]; // RQ27
      div_cnt_r <= 4'h0;
    end else if (src_tick) begin
      div_cnt_r <= div_cnt_r + 4'h1;
    end
  end

  // tick enables gated by power mode
  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      clk_ctl_r <= '0;
    end else begin
      clk_ctl_r.cpu_tick <= sys_tick && mode_r == ST_RUN; // RQ19 RQ20
      clk_ctl_r.periph_tick <= sys_tick && mode_r != ST_STOP &&
        !(mode_r == ST_IDLE && clkreg_r[BIT_PERIPH_STOP]); // RQ18
      clk_ctl_r.fast_osc_en <= fast_on;
      clk_ctl_r.fast_xtal_sel <= clkreg_r[BIT_FAST_TYPE];
      clk_ctl_r.slow_xtal_sel <= clkreg_r[BIT_SLOW_TYPE];
      clk_ctl_r.fast_mode <= act_fast_r;
    end
  end

  // ***************************************************
  // low-voltage detect and read-back
  // ***************************************************
  logic lvd_flag;
  // flag meaningless with the higher reset thresholds
  assign lvd_flag = pin_lvl.lv_below_2v3 && lvsel[1] && mode_r != ST_STOP && // RQ9 RQ10
                    !(option_r[BIT_THREE_VOLT] && cfg_high_r[BIT_POWER_SAVE]); // RQ9

  always_ff @(posedge clk_sys) begin
    if (rst_int) begin
      sfr_rdata_r <= 8'h00;
    end else if (sfr_req.addr == OFS_POWER_MODE) begin
      sfr_rdata_r <= pwr_r;
    end else if (sfr_req.addr == OFS_OPTION) begin
      sfr_rdata_r <= option_r;
    end else if (sfr_req.addr == OFS_INT_FLAG) begin
      sfr_rdata_r <= {lvd_flag, 7'h00};
    end else if (sfr_req.addr == OFS_CLOCK_CTRL) begin
      sfr_rdata_r <= clkreg_r;
    end else if (sfr_req.addr == OFS_AUX_ONE) begin
      sfr_rdata_r <= aux_r;
    end else begin
      sfr_rdata_r <= 8'h00;
    end
  end

endmodule

// File: verification/sysctl_core_checker.sv
// Purpose: port-level checks on the clock, reset and power mode block
// Assumes: one clk_sys domain, synchronous active high reset
// Notes: pins pass a short synchroniser, so pin-driven checks allow slack
`timescale 1ns/1ns
module sysctl_core_checker
  import sysctl_pkg::*;
#(
  parameter int WARMUP_CYCLES = WARMUP_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // inputs of the block
  input wire async_pins_t pins_async,
  input wire sfr_req_t sfr_req,
  input wire logic [2:0] pin_wake_en,
  input wire logic port1_wake,
  input wire logic enabled_irq,
  // outputs of the block
  input wire logic [7:0] sfr_rdata_r,
  input wire logic [7:0] cfg_low_r,
  input wire logic [7:0] cfg_high_r,
  input wire clk_ctl_t clk_ctl_r,
  input wire logic device_reset_r,
  input wire pmode_t mode_r
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  // ***************************************************
  // helper logic
  // ***************************************************
  logic blk_now;
  logic [6:0] blk_hist_r;
  logic warm_r;
  int warm_cnt_r;
  // a low pin with its wake enable both blocks stop entry and ends stop
  assign blk_now = |(~pins_async.ext_int_n & pin_wake_en);
  // history longer than the pin filter, so the block has surely seen it
  always_ff @(posedge clk_sys) begin
    blk_hist_r <= {blk_hist_r[5:0], blk_now};
  end
  // cycles since power-on release, meaningful until device reset first drops
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      warm_r <= 1'b1;
      warm_cnt_r <= 0;
    end else begin
      warm_r <= warm_r & device_reset_r;
      warm_cnt_r <= warm_cnt_r + 1;
    end
  end

  // ***************************************************
  // assertions
  // ***************************************************
  a_warmup_hold: assert property (
    warm_r && warm_cnt_r < WARMUP_CYCLES |-> device_reset_r)
    else $error("reset released before warm-up ended");
  a_sw_reset_pulse: assert property (
    !device_reset_r && sfr_req.wr && sfr_req.addr == OFS_SW_COMMAND
    && sfr_req.wdata == SW_RESET_KEY |=> device_reset_r [*5] ##1 !device_reset_r)
    else $error("software reset pulse wrong");
  a_idle_entry: assert property (
    !device_reset_r && sfr_req.wr && sfr_req.addr == OFS_POWER_MODE
    && sfr_req.wdata[1:0] == 2'b01 && mode_r == ST_RUN && !enabled_irq
    |=> mode_r == ST_IDLE)
    else $error("idle not entered");
  a_idle_wake: assert property (
    mode_r == ST_IDLE && enabled_irq |-> ##[1:3] mode_r == ST_RUN)
    else $error("idle not ended by interrupt");
  a_stop_refused: assert property (
    !device_reset_r && sfr_req.wr && sfr_req.addr == OFS_POWER_MODE
    && sfr_req.wdata[1] && &blk_hist_r |=> mode_r != ST_STOP)
    else $error("stop entered with wake pin low");
  a_stop_holds: assert property (
    mode_r == ST_STOP && blk_hist_r == 7'h00 && !blk_now && !port1_wake
    && !$past(port1_wake) |=> mode_r == ST_STOP || device_reset_r)
    else $error("stop left without pin wake");
  a_stop_pin_wake: assert property (
    mode_r == ST_STOP && blk_now |-> ##[1:10] mode_r == ST_RUN)
    else $error("pin did not wake stop");
  a_stop_quiet: assert property (
    mode_r == ST_STOP && $past(mode_r) == ST_STOP
    |-> !clk_ctl_r.cpu_tick && !clk_ctl_r.periph_tick)
    else $error("clock tick during stop");
  a_lvd_stop: assert property (
    mode_r == ST_STOP && $past(mode_r, 2) == ST_STOP
    && $past(sfr_req.addr) == OFS_INT_FLAG |-> !sfr_rdata_r[7])
    else $error("detect flag set in stop");
  a_cfg_kept: assert property (
    !device_reset_r |=> ($stable(cfg_low_r) && $stable(cfg_high_r)) [*8])
    else $error("config words changed without power-on");
endmodule

// File: verification/testbench.sv
// Purpose: self-checking bench for the clock, reset and power mode block
// Assumes: oscillator pins toggle far slower than clk_sys
// Notes: warm-up shortened to 50 cycles; watchdog timed at the 45 ms setting
`timescale 1ns/1ns
module testbench
  import sysctl_pkg::*;
;
  localparam int WARM = 50;

  // ***************************************************
  // signals and block
  // ***************************************************
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  async_pins_t pins;
  sfr_req_t req;
  logic [7:0] rdata;
  logic [7:0] flash_lo = 8'hC0;
  logic [7:0] flash_hi = 8'h70;
  logic [7:0] cfg_lo;
  logic [7:0] cfg_hi;
  logic [2:0] wake_en;
  logic p1_wake;
  logic irq;
  logic dev_rst;
  logic rst_seen;
  clk_ctl_t ctl;
  pmode_t mode;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;

  sysctl_core #(.WARMUP_CYCLES(WARM)) dut (
    .clk_sys(clk_sys), .reset(reset), .pins_async(pins), .sfr_req(req),
    .sfr_rdata_r(rdata), .flash_cfg_low(flash_lo), .flash_cfg_high(flash_hi),
    .pin_wake_en(wake_en), .port1_wake(p1_wake), .enabled_irq(irq),
    .cfg_low_r(cfg_lo), .cfg_high_r(cfg_hi), .clk_ctl_r(ctl),
    .device_reset_r(dev_rst), .mode_r(mode)
  );

  // 50 ns clock
  always #25 clk_sys = ~clk_sys;

  // oscillators of 10, 14, 8 and 12 cycles, slow enough for the pin filter
  always @(negedge clk_sys) begin
    cyc <= cyc + 1;
    pins.slow_rc <= (cyc % 10) < 5;
    pins.slow_xtal <= (cyc % 14) < 7;
    pins.fast_rc <= (cyc % 8) < 4;
    pins.fast_xtal <= (cyc % 12) < 6;
    if (dev_rst === 1'b1) rst_seen <= 1'b1;
  end

  // ***************************************************
  // shared tasks
  // ***************************************************
  task automatic tally_and_finish();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    step(1);
    req.wr = 1'b0;
    // one idle edge, so back-to-back writes never re-raise the strobe at once
    step(1);
  endtask
  // read data is registered, so it is judged one cycle after the address
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    req.addr = a;
    step(1);
    chk(rdata, e);
  endtask
  // bounded wait for device reset to reach a level; k counts the cycles
  task automatic wait_rst(input logic lvl, input int lim, output int k);
    k = 0;
    while (dev_rst !== lvl) begin
      step(1);
      k++;
      if (k > lim) begin
        chk(dev_rst, lvl);
        tally_and_finish();
      end
    end
  endtask
  // cycles between two cpu ticks, after syncing to one
  task automatic tick_gap(output int g);
    int k;
    k = 0;
    repeat (2) begin
      g = 0;
      do begin
        step(1);
        g++;
        k++;
      end while (ctl.cpu_tick !== 1'b1 && k < 1000);
    end
    if (k >= 1000) begin
      chk(1'b0, 1'b1);
      tally_and_finish();
    end
  endtask
  task automatic count_ticks(input int n, output int c, output int p);
    c = 0;
    p = 0;
    repeat (n) begin
      step(1);
      c += (ctl.cpu_tick !== 1'b0);
      p += (ctl.periph_tick !== 1'b0);
    end
  endtask

  // ***************************************************
  // scenarios
  // ***************************************************
  task automatic run_defaults();
    int k;
    wait_rst(1'b0, 200, k);
    chk(k >= WARM, 1'b1);
    chk({cfg_hi, cfg_lo}, 16'h70C0);
    chk(ctl.fast_mode, 1'b0);
    rd_chk(8'hD8, 8'h03);
    rd_chk(8'h94, 8'h00);
    rd_chk(8'h87, 8'h00);
    rd_chk(8'h80, 8'h00);
  endtask
  // guarded clock writes, fast crystal at divide by 1, then every prescaler setting in slow mode
  task automatic run_clock();
    int div[4] = '{16, 4, 2, 1};
    int g;
    wr(8'hD8, 8'h83);
    rd_chk(8'hD8, 8'h03);
    wr(8'hD8, 8'h43);
    wr(8'hD8, 8'h4F);
    rd_chk(8'hD8, 8'h43);
    wr(8'hD8, 8'h4B);
    step(8);
    chk(ctl.fast_osc_en, 1'b0);
    wr(8'hD8, 8'h4F);
    rd_chk(8'hD8, 8'h4B);
    wr(8'hD8, 8'h43);
    wr(8'hD8, 8'h47);
    step(30);
    chk(ctl.fast_mode, 1'b1);
    wr(8'hD8, 8'h0F);
    rd_chk(8'hD8, 8'h47);
    wr(8'hD8, 8'hC7);
    tick_gap(g);
    tick_gap(g);
    chk(g, 12);
    chk({ctl.slow_xtal_sel, ctl.fast_xtal_sel}, 2'b11);
    wr(8'hD8, 8'h43);
    for (int i = 0; i < 4; i++) begin
      wr(8'hD8, 8'h40 | 8'(i));
      tick_gap(g);
      tick_gap(g);
      chk(g, 10 * div[i]);
    end
  endtask
  task automatic run_idle();
    int c, p;
    for (int s = 0; s < 2; s++) begin
      wr(8'hD8, s ? 8'h53 : 8'h43);
      wr(8'h87, 8'h01);
      count_ticks(40, c, p);
      chk(mode, ST_IDLE);
      chk({c == 0, p != 0}, {1'b1, s == 0});
      irq = 1'b1;
      step(4);
      chk(mode, ST_RUN);
      irq = 1'b0;
      rd_chk(8'h87, 8'h00);
    end
  endtask
  task automatic run_stop();
    int c, p;
    pins.lv_below_2v3 = 1'b1;
    pins.lv_below_2v9 = 1'b1;
    wake_en = 3'b010;
    pins.ext_int_n = 3'b101;
    step(10);
    rd_chk(8'h95, 8'h80);
    wr(8'h87, 8'h02);
    step(3);
    chk(mode, ST_RUN);
    pins.ext_int_n = 3'b111;
    wr(8'h94, 8'h40);
    rd_chk(8'h95, 8'h80);
    step(8);
    wr(8'h87, 8'h02);
    irq = 1'b1;
    pins.ext_int_n = 3'b110;
    count_ticks(40, c, p);
    chk(mode, ST_STOP);
    chk(c + p, 0);
    rd_chk(8'h95, 8'h00);
    irq = 1'b0;
    pins.ext_int_n = 3'b100;
    step(10);
    chk(mode, ST_RUN);
    pins.ext_int_n = 3'b111;
    step(8);
    wr(8'h87, 8'h02);
    step(3);
    p1_wake = 1'b1;
    step(4);
    chk(mode, ST_RUN);
    p1_wake = 1'b0;
    pins.lv_below_2v3 = 1'b0;
  endtask
  task automatic run_resets();
    logic [7:0] bad[3] = '{8'h55, 8'h65, 8'hA9};
    int k;
    foreach (bad[i]) begin
      wr(8'h97, bad[i]);
      step(2);
      chk(dev_rst, 1'b0);
    end
    wr(8'h97, 8'h56);
    wait_rst(1'b0, 20, k);
    chk(k, 4);
    rd_chk(8'hD8, 8'h03);
    rd_chk(8'h94, 8'h00);
    rst_seen = 1'b0;
    pins.reset_pin_n = 1'b0;
    step(8);
    pins.reset_pin_n = 1'b1;
    step(20);
    chk(rst_seen, 1'b0);
    pins.reset_pin_n = 1'b0;
    wait_rst(1'b1, 60, k);
    chk(k >= 10, 1'b1);
    pins.reset_pin_n = 1'b1;
    wait_rst(1'b0, 30, k);
    chk({cfg_hi, cfg_lo}, 16'h70C0);
  endtask
  // 45 ms setting: 1080 slow ticks of 10 cycles, still counting in idle
  task automatic run_watchdog();
    int k, ones;
    ones = 0;
    wr(8'h94, 8'h30);
    wr(8'hF8, 8'h80);
    repeat (4) begin
      ones += (rdata[7] === 1'b1);
      step(1);
    end
    chk(ones, 1);
    step(6000);
    wr(8'hF8, 8'h80);
    wr(8'h87, 8'h01);
    wait_rst(1'b1, 11000, k);
    chk(k > 10700 && k < 10900, 1'b1);
    wait_rst(1'b0, 30, k);
    chk(mode, ST_RUN);
    rd_chk(8'h94, 8'h00);
  endtask

  // ***************************************************
  // main sequence
  // ***************************************************
  initial begin
    pins = '{default: 1'b0};
    pins.ext_int_n = 3'h7;
    pins.reset_pin_n = 1'b1;
    req = '0;
    wake_en = 3'h0;
    p1_wake = 1'b0;
    irq = 1'b0;
    rst_seen = 1'b0;
    step(3);
    reset = 1'b0;
    run_defaults();
    run_clock();
    run_idle();
    run_stop();
    run_resets();
    run_watchdog();
    tally_and_finish();
  end
endmodule

bind sysctl_core sysctl_core_checker #(.WARMUP_CYCLES(WARMUP_CYCLES)) u_chk (
  .clk_sys(clk_sys), .reset(reset), .pins_async(pins_async), .sfr_req(sfr_req),
  .pin_wake_en(pin_wake_en), .port1_wake(port1_wake), .enabled_irq(enabled_irq),
  .sfr_rdata_r(sfr_rdata_r), .cfg_low_r(cfg_low_r), .cfg_high_r(cfg_high_r),
  .clk_ctl_r(clk_ctl_r), .device_reset_r(device_reset_r), .mode_r(mode_r)
);
